// >>> hdl/tr_touch_i2c.sv
/*
  Touch report I2C target: builds 66-byte report frames from contact
  records, serves them to the host over I2C, and answers the firmware
  version query.
  Assumes SCL arrives as its own clock port, SDA as split open-drain
  signals, and a scan engine that offers contact records.
*/
// Functional notes
// - Answer reads and writes at address 0x2A.
// - Hold irq low while frame buffer holds data.
// - Length field is 2 plus payload bytes.
// - Send length low, high, then payload.
// - Payload starts with report id, 0x06 touch.
// - Count byte1, five records, scan time 52-55.
// - Split contacts by five; later counts zero.
// - Record: state, id, X, Y, reserved bytes.
// - Coordinates span 4096 positions per axis.
// - Id 0x03 diagnostics carries stream length.
// - Write payload is a diagnostics packet.
// - Version query answered with 0x42 length frame.
// - Interrupt output is active low.
`timescale 1ns/1ps
`default_nettype none
`include "tr_regs.svh"
module tr_touch_i2c #(
  parameter logic [47:0] FW_VER = 48'h303030303031  // Arbitrary version text
) (
  // Core clock and reset
  input  wire logic           clk,
  input  wire logic           arst_n,
  // I2C link, SCL is the link clock
  input  wire logic           scl_clk,
  input  wire logic           sda_i,
  output logic                sda_o,
  output logic                sda_oe,
  // Data-ready interrupt
  output logic                irq_n,
  // Contact records from the scan engine
  input  wire logic           rec_valid,
  input  wire tr_pkg::tr_rec_s rec,
  output logic                rec_ready
);
  // ==========================================================
  // State
  tr_pkg::tr_pos_s p_r;    // Rising SCL state
  tr_pkg::tr_pos_s p_nxt;
  tr_pkg::tr_neg_s n_r;    // Falling SCL state
  tr_pkg::tr_neg_s n_nxt;
  tr_pkg::tr_clk_s c_r;    // Core state
  tr_pkg::tr_clk_s c_nxt;
  logic st_tgl_r;          // Toggles on START
  logic sp_tgl_r;          // Toggles on STOP
  tr_pkg::tr_byte_t nb;    // Byte with newest bit
  logic ev_wr;             // Core-side events
  logic ev_rd;
  logic ev_st;
  logic ev_sp;
  logic wmatch;            // Written byte as expected

  // ==========================================================
  // START and STOP detection
  // SDA edges while SCL is high; SCL stands still around these,
  // so the SCL domain sees the toggle at the next rising SCL edge.
  always_ff @(negedge sda_i or negedge arst_n) begin
    if (!arst_n) begin
      st_tgl_r <= 1'b0;
    end else if (scl_clk) begin
      st_tgl_r <= ~st_tgl_r;
    end
  end

  // STOP never reaches SCL logic; only the core uses it
  always_ff @(posedge sda_i or negedge arst_n) begin
    if (!arst_n) begin
      sp_tgl_r <= 1'b0;
    end else if (scl_clk) begin
      sp_tgl_r <= ~sp_tgl_r;
    end
  end

  // ==========================================================
  // Link receive side, rising SCL
  always_comb begin
    p_nxt = p_r;
    nb    = {p_r.sh[6:0], sda_i};
    if (st_tgl_r != p_r.st_seen) begin
      // New frame: this edge carries address bit 6
      p_nxt.st_seen = st_tgl_r;
      p_nxt.ph      = tr_pkg::TR_PH_ADDR;
      p_nxt.bcnt    = 4'h1;
      p_nxt.sh      = {7'h00, sda_i};
      p_nxt.ack_due = 1'b0;
      p_nxt.rd      = 1'b0;
      p_nxt.hack    = 1'b0;
      p_nxt.ridx    = 7'h00;
    end else begin
      case (p_r.ph)
        tr_pkg::TR_PH_IDLE: begin
          p_nxt.bcnt = 4'h0;
        end
        tr_pkg::TR_PH_ADDR, tr_pkg::TR_PH_DATA: begin
          if (p_r.bcnt == `TR_ACK_BIT) begin
            // Ninth bit
            p_nxt.bcnt = 4'h0;
            if (p_r.ack_due) begin
              p_nxt.ack_due = 1'b0;
            end else if (p_r.rd) begin
              p_nxt.hack = ~sda_i;
              if (p_r.ridx == `TR_LAST_IDX) begin
                p_nxt.rd_tgl = ~p_r.rd_tgl;
              end else begin
                p_nxt.ridx = p_r.ridx + 7'h01;
              end
              // Nak ends our driving until the next START
              if (sda_i) begin
                p_nxt.ph = tr_pkg::TR_PH_IDLE;
              end
            end
          end else begin
            p_nxt.sh   = nb;
            p_nxt.bcnt = p_r.bcnt + 4'h1;
            if (p_r.bcnt == `TR_LAST_BIT) begin
              if (p_r.ph == tr_pkg::TR_PH_ADDR) begin
                // Address byte complete
                if (nb[7:1] == `TR_DEV_ADDR) begin
                  p_nxt.ph      = tr_pkg::TR_PH_DATA;
                  p_nxt.rd      = nb[0];
                  p_nxt.ack_due = 1'b1;
                  p_nxt.hack    = nb[0];
                end else begin
                  p_nxt.ph = tr_pkg::TR_PH_IDLE;
                end
              end else if (!p_r.rd) begin
                // Written byte handed to core by toggle
                p_nxt.wbyte   = nb;
                p_nxt.wr_tgl  = ~p_r.wr_tgl;
                p_nxt.ack_due = 1'b1;
              end
            end
          end
        end
        default: begin
          p_nxt.ph = tr_pkg::TR_PH_IDLE;
        end
      endcase
    end
  end

  // Reset leaves the link idle
  always_ff @(posedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      p_r    <= '0;
      p_r.ph <= tr_pkg::TR_PH_IDLE;
    end else begin
      p_r <= p_nxt;
    end
  end

  // ==========================================================
  // Link drive side, falling SCL
  // The frame buffer is read here across domains: it only
  // changes while irq is high, when the host does not read.
  always_comb begin
    n_nxt        = '0;
    n_nxt.sda_o  = 1'b0;
    if (p_r.ph == tr_pkg::TR_PH_DATA) begin
      if (p_r.bcnt == `TR_ACK_BIT) begin
        n_nxt.sda_oe = p_r.ack_due;
      end else if (p_r.rd && p_r.hack) begin
        // Open drain: pull low for a zero bit
        n_nxt.sda_oe = ~c_r.frm[p_r.ridx][~p_r.bcnt[2:0]];
      end
    end
  end

  // Released on reset
  always_ff @(negedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      n_r <= '0;
    end else begin
      n_r <= n_nxt;
    end
  end

  // ==========================================================
  // Core: crossings, command decode, frame builder
  always_comb begin
    c_nxt = c_r;
    // Two-stage synchronisers of the link toggles
    c_nxt.s_wr = {c_r.s_wr[0], p_r.wr_tgl};
    c_nxt.s_rd = {c_r.s_rd[0], p_r.rd_tgl};
    c_nxt.s_st = {c_r.s_st[0], st_tgl_r};
    c_nxt.s_sp = {c_r.s_sp[0], sp_tgl_r};
    c_nxt.p_wr = c_r.s_wr[1];
    c_nxt.p_rd = c_r.s_rd[1];
    c_nxt.p_st = c_r.s_st[1];
    c_nxt.p_sp = c_r.s_sp[1];
    ev_wr = c_r.s_wr[1] ^ c_r.p_wr;
    ev_rd = c_r.s_rd[1] ^ c_r.p_rd;
    ev_st = c_r.s_st[1] ^ c_r.p_st;
    ev_sp = c_r.s_sp[1] ^ c_r.p_sp;
    // Expected command bytes; frame length bytes are not checked
    case (c_r.widx)
      `TR_WI_PFX0: wmatch = (p_r.wbyte == `TR_WR_PFX0);
      `TR_WI_PFX1: wmatch = (p_r.wbyte == `TR_WR_PFX1);
      `TR_WI_RID:  wmatch = (p_r.wbyte == `TR_RID_DIAG);
      `TR_WI_DLEN: wmatch = (p_r.wbyte == `TR_CMD_DLEN);
      `TR_WI_CMD:  wmatch = (p_r.wbyte == `TR_VER_CMD);
      default:     wmatch = 1'b1;
    endcase

    // Last read byte sent: frame consumed
    if (ev_rd) begin
      c_nxt.full = 1'b0;
      c_nxt.frm  = '0;
    end

    // Version answer takes priority between touch report frames
    if (!c_nxt.full && c_nxt.slot == 3'h0 && c_nxt.ver_pend) begin
      c_nxt.ver_pend             = 1'b0;
      c_nxt.frm[`TR_FI_LENL]     = `TR_LEN_FULL;
      c_nxt.frm[`TR_FI_LENH]     = 8'h00;
      c_nxt.frm[`TR_FI_RID]      = `TR_RID_DIAG;
      c_nxt.frm[`TR_FI_CNT]      = `TR_VER_DLEN;
      c_nxt.frm[`TR_FI_DATA]     = `TR_VER_CMD;
      for (int k = 0; k < `TR_VER_CHARS; k++) begin
        c_nxt.frm[`TR_FI_DATA + 7'(k + 1)] = FW_VER[8*(5-k) +: 8];
      end
      c_nxt.full = 1'b1;
    end else if (rec_valid && c_r.rec_rdy) begin
      // Place one record in its slot
      for (int s = 0; s <= 4; s++) begin
        if (c_r.slot == 3'(s)) begin
          c_nxt.frm[`TR_FI_REC + 7'(10*s)]     = {7'h00, rec.down};
          c_nxt.frm[`TR_FI_REC + 7'(10*s + 1)] = rec.ident;
          c_nxt.frm[`TR_FI_REC + 7'(10*s + 2)] = rec.x[7:0];
          c_nxt.frm[`TR_FI_REC + 7'(10*s + 3)] = {4'h0, rec.x[11:8]};
          c_nxt.frm[`TR_FI_REC + 7'(10*s + 4)] = rec.y[7:0];
          c_nxt.frm[`TR_FI_REC + 7'(10*s + 5)] = {4'h0, rec.y[11:8]};
        end
      end
      // Count only in the first frame of a report
      if (c_r.slot == 3'h0) begin
        c_nxt.frm[`TR_FI_CNT] = c_r.first ? rec.total : 8'h00;
      end
      if (c_r.slot == `TR_MAX_SLOT || rec.last) begin
        // Frame closes after five records or report end
        c_nxt.frm[`TR_FI_LENL] = `TR_LEN_TOUCH;
        c_nxt.frm[`TR_FI_LENH] = 8'h00;
        c_nxt.frm[`TR_FI_RID]  = `TR_RID_TOUCH;
        for (int b = 0; b < 4; b++) begin
          c_nxt.frm[`TR_FI_SCAN + 7'(b)] = rec.scan_time[8*b +: 8];
        end
        c_nxt.slot  = 3'h0;
        c_nxt.first = rec.last;
        c_nxt.full  = 1'b1;
      end else begin
        c_nxt.slot = c_r.slot + 3'h1;
      end
    end

    // Write frame tracking
    if (ev_st) begin
      c_nxt.widx = 7'h00;
      c_nxt.wok  = 1'b1;
    end else if (ev_wr) begin
      c_nxt.wok = c_r.wok & wmatch;
      if (c_r.widx != `TR_WI_MAX) begin
        c_nxt.widx = c_r.widx + 7'h01;
      end
    end
    // Set after the clear above, so a query is never lost
    if (ev_sp && c_r.widx >= `TR_WI_MIN && c_r.wok) begin
      c_nxt.ver_pend = 1'b1;
    end

    c_nxt.rec_rdy = ~c_nxt.full & ~(c_nxt.ver_pend && c_nxt.slot == 3'h0);
    c_nxt.irq_n   = ~c_nxt.full;
  end

  // Core register; first report frame starts a report
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      c_r       <= '0;
      c_r.first <= 1'b1;
      c_r.wok   <= 1'b1;
      c_r.irq_n <= 1'b1;
    end else begin
      c_r <= c_nxt;
    end
  end

  // ==========================================================
  // Outputs, each from a flip-flop
  assign sda_o     = n_r.sda_o;
  assign sda_oe    = n_r.sda_oe;
  assign irq_n     = c_r.irq_n;
  assign rec_ready = c_r.rec_rdy;
endmodule
`default_nettype wire

// >>> hdl/tr_regs.svh
/*
  Constants of the touch report I2C target: bus address, frame layout,
  command bytes and counts.
  Assumes inclusion by tr_pkg.sv and tr_touch_i2c.sv.
*/
`ifndef TR_REGS_SVH
`define TR_REGS_SVH
// ==========================================================
// Link constants
`define TR_DEV_ADDR   7'h2a
`define TR_LAST_IDX   7'h41
`define TR_ACK_BIT    4'h8
`define TR_LAST_BIT   4'h7
// ==========================================================
// Read frame layout (frame index = payload index + 2)
`define TR_LEN_TOUCH  8'h3a
`define TR_LEN_FULL   8'h42
`define TR_RID_TOUCH  8'h06
`define TR_RID_DIAG   8'h03
`define TR_FI_LENL    7'h00
`define TR_FI_LENH    7'h01
`define TR_FI_RID     7'h02
`define TR_FI_CNT     7'h03
`define TR_FI_DATA    7'h04
`define TR_FI_REC     7'h04
`define TR_REC_STRIDE 7'h0a
`define TR_FI_SCAN    7'h36
`define TR_MAX_SLOT   3'h4
`define TR_VER_CHARS  6
// ==========================================================
// Host command frame
`define TR_WR_PFX0    8'h67
`define TR_WR_PFX1    8'h00
`define TR_CMD_DLEN   8'h01
`define TR_VER_CMD    8'h44
`define TR_VER_DLEN   8'h07
`define TR_WI_PFX0    7'h00
`define TR_WI_PFX1    7'h01
`define TR_WI_RID     7'h04
`define TR_WI_DLEN    7'h05
`define TR_WI_CMD     7'h06
`define TR_WI_MIN     7'h07
`define TR_WI_MAX     7'h7f
`endif

// >>> hdl/tr_pkg.sv
/*
  Types of the touch report I2C target: state structs and phases.
  Assumes tr_regs.svh on the include path.
*/
`include "tr_regs.svh"
package tr_pkg;
  // ==========================================================
  // Shared types
  typedef logic [7:0] tr_byte_t;
  // One contact record offered by the scan logic
  typedef struct packed {
    logic [7:0]  total;     // Contacts in whole report
    logic        last;      // Last record of report
    logic [31:0] scan_time; // Scan time stamp
    logic        down;      // Touch down when set
    logic [7:0]  ident;     // contact_identifier
    logic [11:0] x;         // 0..4095
    logic [11:0] y;         // 0..4095
  } tr_rec_s;
  // Link phase, one-hot
  typedef enum logic [2:0] {
    TR_PH_IDLE = 3'b001,
    TR_PH_ADDR = 3'b010,
    TR_PH_DATA = 3'b100
  } tr_phase_e;
  // Link state sampled on rising SCL
  typedef struct packed {
    tr_phase_e  ph;
    logic [3:0] bcnt;     // Bits of current byte
    tr_byte_t   sh;       // Receive shifter
    logic       rd;       // Read transfer
    logic       ack_due;  // Device acks this byte
    logic       hack;     // Host acked last byte
    logic [6:0] ridx;     // Read byte index
    tr_byte_t   wbyte;    // Last written byte
    logic       wr_tgl;   // Toggles per written byte
    logic       rd_tgl;   // Toggles on last read byte
    logic       st_seen;  // Copy of start toggle
  } tr_pos_s;
  // Link state driven on falling SCL
  typedef struct packed {
    logic sda_oe;
    logic sda_o;
  } tr_neg_s;
  // Core state on clk
  typedef struct packed {
    logic [65:0][7:0] frm;  // Output frame buffer
    logic       full;
    logic [2:0] slot;
    logic       first;
    logic       ver_pend;
    logic [6:0] widx;
    logic       wok;
    logic [1:0] s_wr;
    logic [1:0] s_rd;
    logic [1:0] s_st;
    logic [1:0] s_sp;
    logic       p_wr;
    logic       p_rd;
    logic       p_st;
    logic       p_sp;
    logic       rec_rdy;
    logic       irq_n;
  } tr_clk_s;
endpackage

// >>> testbench/tr_touch_i2c_monitor.sv
/*
  Port checker of the touch report I2C target.
  Assumes binding onto tr_touch_i2c; SDA wire level arrives on sda_i.
*/
`timescale 1ns/1ps
`default_nettype none
module tr_touch_mon (
  // Clocks and reset
  input wire logic            clk,
  input wire logic            arst_n,
  input wire logic            scl_clk,
  // Link
  input wire logic            sda_i,
  input wire logic            sda_o,
  input wire logic            sda_oe,
  // Core side
  input wire logic            irq_n,
  input wire logic            rec_valid,
  input wire tr_pkg::tr_rec_s rec,
  input wire logic            rec_ready
);
  // ==========================================================
  // Slot tracker
  wire logic  take = rec_valid && rec_ready; // Record taken
  logic [2:0] cnt_r;                         // Records in open frame
  // Restarts on report end or fifth slot
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      cnt_r <= 3'h0;
    else if (take)
      cnt_r <= (rec.last || cnt_r == 3'h4) ? 3'h0 : cnt_r + 3'h1;
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_odrain; sda_o == 1'b0; endproperty
  a_odrain: assert property (p_odrain) else $error("sda_o not low");
  property p_rst; $rose(arst_n) |-> irq_n && !rec_ready; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_busy; !irq_n |-> !rec_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready while frame waits");
  property p_last; take && rec.last |=> !irq_n && !rec_ready; endproperty
  a_last: assert property (p_last) else $error("report end not posted");
  property p_mid; take && !rec.last && cnt_r < 3'h4 |=> rec_ready && irq_n; endproperty
  a_mid: assert property (p_mid) else $error("frame closed early");
  property p_fifth; take && cnt_r == 3'h4 |-> ##1 (!irq_n && !rec_ready) [*2]; endproperty
  a_fifth: assert property (p_fifth) else $error("fifth record not closing");
  property p_edge; $changed(sda_oe) |-> !scl_clk; endproperty
  a_edge: assert property (p_edge) else $error("sda_oe moved with scl high");
  property p_rise; $rose(rec_ready) |-> irq_n; endproperty
  a_rise: assert property (p_rise) else $error("ready with irq low");
  // Main scenarios reached
  c_last: cover property (take && rec.last);
  c_irq: cover property ($fell(irq_n));
  c_drive: cover property ($rose(sda_oe));
endmodule
bind tr_touch_i2c tr_touch_mon u_tr_touch_mon (.clk(clk), .arst_n(arst_n),
  .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq_n(irq_n),
  .rec_valid(rec_valid), .rec(rec), .rec_ready(rec_ready));
`default_nettype wire

// >>> testbench/tr_host_model.sv
/*
  I2C host model: reads and writes whole 66/68 byte frames.
  Assumes a pulled-up SDA wire fed back on sda; SCL idles high.
*/
`timescale 1ns/1ps
`default_nettype none
module tr_host_model (
  // Wire level seen
  input wire logic sda,
  // Host lines
  output logic     scl,
  output logic     pull
);
  logic [7:0] rbuf [66]; // Last frame read
  logic [7:0] wbuf [68]; // Frame to write
  int         ack_n;     // Acks seen in a write
  // Idle bus, clock stands still
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // One bit slot of 32 ns, ends with SCL high
  // Far faster than the advised bus rate, only to keep runs short
  task automatic bit_x(input logic b, output logic r);
    scl = 1'b0;
    #8 pull = ~b;
    #8 scl = 1'b1;
    #8 r = sda;
    #8;
  endtask
  // Byte MSB first, then acknowledge slot
  task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic ak);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(a, ak);
  endtask
  task automatic start;
    pull = 1'b1;
    // Odd hold keeps SCL edges off the core clock edges
    #11;
  endtask
  task automatic stop;
    scl = 1'b0;
    #8 pull = 1'b1;
    #8 scl = 1'b1;
    #8 pull = 1'b0;
    #16;
  endtask
  // Whole read: ack each byte, nak the last
  task automatic rd_frame(input logic [6:0] ad);
    logic [7:0] q;
    logic       ak;
    start;
    byte_x({ad, 1'b1}, 1'b1, q, ak);
    for (int i = 0; i < 66; i++)
      byte_x(8'hff, i == 65, rbuf[i], ak);
    stop;
  endtask
  // Whole write of prefix, length and 64 byte payload
  task automatic wr_frame(input logic [6:0] ad);
    logic [7:0] q;
    logic       ak;
    start;
    byte_x({ad, 1'b0}, 1'b1, q, ak);
    ack_n = int'(!ak);
    for (int i = 0; i < 68; i++) begin
      byte_x(wbuf[i], 1'b1, q, ak);
      ack_n += int'(!ak);
    end
    stop;
  endtask
endmodule
`default_nettype wire

// >>> testbench/tr_touch_i2c_tb.sv
/*
  Bench of the touch report I2C target: record feeder, host model, checks.
  Assumes tr_pkg and the host model compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tr_touch_i2c_tb;
  localparam logic [47:0] VER = 48'h303030303031; // Arbitrary version text
  localparam logic [7:0] CMD [7] = '{8'h67, 8'h00, 8'h42, 8'h00, 8'h03, 8'h01, 8'h44};
  logic            clk, arst_n, rec_valid, scl, pull, sda_o, sda_oe, irq_n, rec_ready;
  tr_pkg::tr_rec_s rec;                       // Record offered
  tr_pkg::tr_rec_s rr [10];                   // Records of one report
  logic [7:0]      fr [66];                   // Frame as read
  int              bad_count, compares, nrec;
  int              seed = 58;
  int              nl [4] = '{1, 5, 7, 10};   // Report sizes
  wire logic       sda = ~(sda_oe | pull);    // Pulled-up wire
  tr_touch_i2c #(.FW_VER(VER)) u_tr_touch_i2c (.clk(clk), .arst_n(arst_n),
    .scl_clk(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .irq_n(irq_n),
    .rec_valid(rec_valid), .rec(rec), .rec_ready(rec_ready));
  tr_host_model u_tr_host_model (.sda(sda), .scl(scl), .pull(pull));
  // ==========================================================
  // Clock and helpers
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic results;
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Expected byte of the version answer frame
  function automatic logic [7:0] ver_byte(input int i);
    if (i < 3) begin
      return CMD[i + 2];
    end else if (i == 3) begin
      return 8'h07;
    end else if (i == 4) begin
      return 8'h44;
    end else if (i < 11) begin
      return VER[47 - 8 * (i - 5) -: 8];
    end else begin
      return 8'h00;
    end
  endfunction
  // Bounded wait on the interrupt level
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq_n !== lvl && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n == 3000) begin
      bad_count++;
      results;
    end
  endtask
  // Offers records, holding each until taken
  task automatic feed;
    int n;
    for (int j = 0; j < nrec; j++) begin
      @(negedge clk);
      rec = rr[j];
      rec_valid = 1'b1;
      n = 0;
      while (rec_ready !== 1'b1 && n < 20000) begin
        @(negedge clk);
        n++;
      end
      if (n == 20000) begin
        bad_count++;
        results;
      end
      @(posedge clk);
    end
    @(negedge clk);
    rec_valid = 1'b0;
  endtask
  // Reads every frame of one report, each once irq goes low
  task automatic read_report;
    int j;
    for (int f = 0; f * 5 < nrec; f++) begin
      wait_irq(1'b0);
      u_tr_host_model.rd_frame(7'h2a);
      fr = u_tr_host_model.rbuf;
      chk(fr[0], 8'h3a);
      chk(fr[1], 8'h00);
      chk(fr[2], 8'h06);
      chk(fr[3], f == 0 ? 8'(nrec) : 8'h00);
      for (int k = 0; k < 5; k++) begin
        j = f * 5 + k;
        if (j < nrec) begin
          chk(fr[4 + 10 * k], {7'h00, rr[j].down});
          chk(fr[5 + 10 * k], rr[j].ident);
          chk(fr[6 + 10 * k], rr[j].x[7:0]);
          chk(fr[7 + 10 * k], {4'h0, rr[j].x[11:8]});
          chk(fr[8 + 10 * k], rr[j].y[7:0]);
          chk(fr[9 + 10 * k], {4'h0, rr[j].y[11:8]});
        end
      end
      for (int b = 0; b < 4; b++)
        chk(fr[54 + b], rr[0].scan_time[8 * b +: 8]);
    end
    wait_irq(1'b1);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    rec_valid = 1'b0;
    rec = '0;
    bad_count = 0;
    compares = 0;
    repeat (10) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    chk({7'h00, irq_n}, 8'h01);
    chk({7'h00, sda_oe}, 8'h00);
    // Touch reports, one frame per five contacts
    foreach (nl[r]) begin
      nrec = nl[r];
      for (int j = 0; j < nrec; j++) begin
        rr[j] = 74'({$random(seed), $random(seed), $random(seed)});
        rr[j].total = 8'(nrec);
        rr[j].last = (j == nrec - 1);
        rr[j].scan_time = 32'h0a0b0c0d + r;
        if (j == 0)
          rr[j].x = 12'hfff;
      end
      fork
        feed;
        read_report;
      join
    end
    // Unknown command, then wrong address, then version query
    foreach (u_tr_host_model.wbuf[i])
      u_tr_host_model.wbuf[i] = 8'h00;
    for (int i = 0; i < 7; i++)
      u_tr_host_model.wbuf[i] = CMD[i];
    u_tr_host_model.wbuf[6] = 8'h45;
    u_tr_host_model.wr_frame(7'h2a);
    chk(8'(u_tr_host_model.ack_n), 8'h45);
    repeat (200) @(posedge clk);
    chk({7'h00, irq_n}, 8'h01);
    u_tr_host_model.wr_frame(7'h2b);
    chk(8'(u_tr_host_model.ack_n), 8'h00);
    u_tr_host_model.wbuf[6] = 8'h44;
    u_tr_host_model.wr_frame(7'h2a);
    wait_irq(1'b0);
    u_tr_host_model.rd_frame(7'h2a);
    fr = u_tr_host_model.rbuf;
    for (int i = 0; i < 66; i++)
      chk(fr[i], ver_byte(i));
    chk(fr[3], 8'h07);
    wait_irq(1'b1);
    results;
  end
endmodule
`default_nettype wire
